// *** src/sim_ctrl_pkg.sv ***
`default_nettype none
package sim_ctrl_pkg;
  localparam int N_AO = 8;
  localparam int PCT_W = 7;
  localparam logic [6:0] PCT_MAX = 7'h64;
  localparam int UA_W = 15;
  // 4 mA floor, 16000 uA span over 100 steps
  localparam logic [14:0] UA_LO = 15'h0fa0;
  localparam logic [14:0] UA_HI = 15'h4e20;
  localparam logic [14:0] UA_STEP = 15'h00a0;
  localparam int N_REL = 8;
  localparam int REL_TRIP = 0;
  localparam int REL_CLOSE = 1;
  localparam int REL_AUX_LO = 2;
  localparam int REL_AUX_HI = 6;
  localparam int REL_SELF = 7;
  localparam int N_ALLOW = 5;
  localparam logic CB_SIM_RST = 1'b1;
  localparam logic [4:0] ALLOW_RST = 5'h00;
  localparam int ANG_W = 9;
  localparam logic [8:0] ANG_A = 9'h000;
  localparam logic [8:0] ANG_B = 9'h078;
  localparam logic [8:0] ANG_C = 9'h0f0;

  typedef enum logic [1:0] {
    ST_DISABLED = 2'h0,
    ST_PREFAULT = 2'h1,
    ST_FAULT = 2'h2,
    ST_POSTFAULT = 2'h3
  } sim_st_t;

  function automatic logic [14:0] pct_to_ua(input logic [6:0] p);
    logic [14:0] w;
    w = {8'h00, p};
    return 15'(UA_LO + 15'(w * UA_STEP));
  endfunction : pct_to_ua
endpackage : sim_ctrl_pkg
`default_nettype wire

// *** src/test_sim_ctrl.sv ***
// Function
// - Force enable overrides analog outputs; cleared at reset.
// - Eight forced levels, each 0 to 100 percent in 1 percent steps.
// - Percent maps linearly onto 4 to 20 mA span.
// - Four states; any but Disabled means simulation, real analog inputs ignored.
// - Self-test warning relay de-energized during simulation.
// - Simulation stops real sampling and selects synthesized samples.
// - Prefault: nominal voltage and frequency, neutral zero, balanced currents.
// - Fault: programmed values, neutral and zero-sequence from vector sums.
// - Postfault: zero currents, bus balanced at 0/120/240 degrees.
// - Breaker simulation blocks trip/close, ignores aux, shows simulated position.
// - Without breaker simulation, relays act and aux contacts give position.
// - Prefault goes to Fault on write or simulate-fault contact closure.
// - Fault holds until trip, then opens breaker and shows Postfault.
// - Postfault holds until close request, then Prefault, close relay blocked.
// - Writing Disabled ends simulation from any state.
// - Aux relays 3-7 act only if allowed; default none; self-test never.
// - Other logic inputs stay monitored; only aux contacts ignored.
// - Without breaker simulation, state follows monitored breaker position.
`default_nettype none
module test_sim_ctrl
  import sim_ctrl_pkg::*;
#(
  parameter int NUM_AO = N_AO
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic ao_en_wr,
  input wire logic ao_en_val,
  input wire logic ao_lvl_wr,
  input wire logic [2:0] ao_lvl_idx,
  input wire logic [6:0] ao_lvl_pct,
  input wire logic [NUM_AO-1:0][14:0] ao_normal_ua,
  output logic [NUM_AO-1:0][14:0] ao_out_ua,
  output logic ao_forced,
  input wire logic sim_wr,
  input wire logic [1:0] sim_wr_state,
  input wire logic cfg_wr,
  input wire logic cfg_cb_sim,
  input wire logic [4:0] cfg_allow,
  input wire logic sim_fault_pin,
  input wire logic breaker_closed_aux_contact,
  input wire logic breaker_open_aux_contact,
  input wire logic trip_req,
  input wire logic close_req,
  input wire logic [7:0] relay_req,
  input wire logic selftest_ok,
  output logic [7:0] relay_out,
  output logic brk_open_ind,
  output logic brk_closed_ind,
  output logic sim_active,
  output logic [1:0] sim_state,
  output logic cb_sim,
  output logic ac_acq_en,
  output logic aux_contacts_ignored,
  output logic prof_nominal,
  output logic neutral_zero,
  output logic neutral_vsum,
  output logic v0_vsum,
  output logic currents_zero,
  output logic bus_balanced,
  output logic [8:0] bus_ang_a,
  output logic [8:0] bus_ang_b,
  output logic [8:0] bus_ang_c
);

  if (NUM_AO < 1 || NUM_AO > N_AO) begin : g_bad_ao
    $error("NUM_AO must be 1 to 8");
  end

  logic [NUM_AO-1:0][6:0] lvl_q;
  logic force_q;
  sim_st_t st_q;
  logic cb_sim_q;
  logic [4:0] allow_q;
  logic brk_sim_q;
  logic fp_s1_q, fp_s2_q, fp_s3_q;
  logic cl_s1_q, cl_s2_q, op_s1_q, op_s2_q;
  logic fault_edge;
  logic sim_on;
  logic brk_real_closed;
  logic [7:0] relay_d;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      force_q <= 1'b0;
    end else if (ao_en_wr) begin
      force_q <= ao_en_val;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      lvl_q <= '0;
    end else if (ao_lvl_wr && ao_lvl_pct <= PCT_MAX && 32'(ao_lvl_idx) < NUM_AO) begin
      lvl_q[ao_lvl_idx] <= ao_lvl_pct;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      ao_out_ua <= '0;
    end else begin
      for (int i = 0; i < NUM_AO; i++) begin
        ao_out_ua[i] <= force_q ? pct_to_ua(lvl_q[i]) : ao_normal_ua[i];
      end
    end
  end

  assign ao_forced = force_q;

  // Pin synchronisers
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      fp_s1_q <= 1'b0;
      fp_s2_q <= 1'b0;
      fp_s3_q <= 1'b0;
      cl_s1_q <= 1'b0;
      cl_s2_q <= 1'b0;
      op_s1_q <= 1'b0;
      op_s2_q <= 1'b0;
    end else begin
      fp_s1_q <= sim_fault_pin;
      fp_s2_q <= fp_s1_q;
      fp_s3_q <= fp_s2_q;
      cl_s1_q <= breaker_closed_aux_contact;
      cl_s2_q <= cl_s1_q;
      op_s1_q <= breaker_open_aux_contact;
      op_s2_q <= op_s1_q;
    end
  end

  assign fault_edge = fp_s2_q && !fp_s3_q;
  assign brk_real_closed = cl_s2_q;

  // Simulation setup
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      cb_sim_q <= CB_SIM_RST;
      allow_q <= ALLOW_RST;
    end else if (cfg_wr) begin
      cb_sim_q <= cfg_cb_sim;
      allow_q <= cfg_allow;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      st_q <= ST_DISABLED;
    end else if (sim_wr) begin
      st_q <= sim_st_t'(sim_wr_state);
    end else begin
      unique case (st_q)
        ST_DISABLED: begin
        end
        ST_PREFAULT: begin
          if (fault_edge) begin
            st_q <= ST_FAULT;
          end
        end
        ST_FAULT: begin
          if (cb_sim_q ? trip_req : !brk_real_closed) begin
            st_q <= ST_POSTFAULT;
          end
        end
        ST_POSTFAULT: begin
          if (cb_sim_q ? close_req : brk_real_closed) begin
            st_q <= ST_PREFAULT;
          end
        end
      endcase
    end
  end

  assign sim_on = st_q != ST_DISABLED;
  assign sim_active = sim_on;
  assign sim_state = st_q;
  assign cb_sim = cb_sim_q;
  assign ac_acq_en = !sim_on;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      brk_sim_q <= 1'b1;
    end else if (!sim_on) begin
      brk_sim_q <= 1'b1;
    end else if (!sim_wr && st_q == ST_FAULT && cb_sim_q && trip_req) begin
      brk_sim_q <= 1'b0;
    end else if (!sim_wr && st_q == ST_POSTFAULT && cb_sim_q && close_req) begin
      brk_sim_q <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      brk_closed_ind <= 1'b0;
      brk_open_ind <= 1'b0;
      aux_contacts_ignored <= 1'b0;
    end else if (sim_on && cb_sim_q) begin
      brk_closed_ind <= brk_sim_q;
      brk_open_ind <= !brk_sim_q;
      aux_contacts_ignored <= 1'b1;
    end else begin
      brk_closed_ind <= cl_s2_q;
      brk_open_ind <= op_s2_q;
      aux_contacts_ignored <= 1'b0;
    end
  end

  // Relay gating
  always_comb begin
    relay_d = relay_req;
    relay_d[REL_SELF] = selftest_ok;
    if (sim_on) begin
      if (cb_sim_q) begin
        relay_d[REL_TRIP] = 1'b0;
        relay_d[REL_CLOSE] = 1'b0;
      end
      relay_d[REL_AUX_HI:REL_AUX_LO] = relay_req[REL_AUX_HI:REL_AUX_LO] & allow_q;
      relay_d[REL_SELF] = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      relay_out <= '0;
    end else begin
      relay_out <= relay_d;
    end
  end

  // Phasor profile selection
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      prof_nominal <= 1'b0;
      neutral_zero <= 1'b0;
      neutral_vsum <= 1'b0;
      v0_vsum <= 1'b0;
      currents_zero <= 1'b0;
      bus_balanced <= 1'b0;
      bus_ang_a <= ANG_A;
      bus_ang_b <= ANG_A;
      bus_ang_c <= ANG_A;
    end else begin
      prof_nominal <= st_q == ST_PREFAULT;
      neutral_zero <= st_q == ST_PREFAULT;
      neutral_vsum <= st_q == ST_FAULT;
      v0_vsum <= st_q == ST_FAULT;
      currents_zero <= st_q == ST_POSTFAULT;
      bus_balanced <= st_q == ST_POSTFAULT;
      bus_ang_a <= ANG_A;
      bus_ang_b <= (st_q == ST_POSTFAULT) ? ANG_B : ANG_A;
      bus_ang_c <= (st_q == ST_POSTFAULT) ? ANG_C : ANG_A;
    end
  end

  default clocking cb_dflt @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);

  a_force_en_take: assert property (ao_en_wr && ao_en_val |=> ao_forced ##1
    (ao_forced || $past(ao_en_wr && !ao_en_val)))
    else $error("force enable not taken");
  a_force_out_map: assert property (ao_forced && $stable(lvl_q[0]) |=>
    ao_out_ua[0] == pct_to_ua($past(lvl_q[0])))
    else $error("forced output mismatch");
  a_lvl_over_ignored: assert property (ao_lvl_wr && ao_lvl_pct > PCT_MAX |=> $stable(lvl_q))
    else $error("out of range level stored");
  a_state_write: assert property (sim_wr |=> sim_state == $past(sim_wr_state))
    else $error("state write not shown");
  a_selftest_drop: assert property (sim_active |=> !relay_out[REL_SELF])
    else $error("warning relay energized in simulation");
  a_acq_stopped: assert property (sim_active |-> !ac_acq_en)
    else $error("real sampling during simulation");
  a_fault_entry: assert property (st_q == ST_PREFAULT && fault_edge && !sim_wr |=>
    st_q == ST_FAULT)
    else $error("fault entry missed");
  a_trip_to_post: assert property (st_q == ST_FAULT && cb_sim_q && trip_req && !sim_wr
    && !cfg_wr |=> sim_state == ST_POSTFAULT ##1 brk_open_ind)
    else $error("trip did not reach postfault");
  a_close_to_pre: assert property (st_q == ST_POSTFAULT && cb_sim_q && close_req && !sim_wr
    |=> st_q == ST_PREFAULT)
    else $error("close did not reach prefault");
  a_trip_close_blk: assert property (sim_active && cb_sim_q |=> relay_out[1:0] == 2'h0)
    else $error("trip or close relay operated");
  a_aux_mask: assert property (sim_active && !allow_q[0] |=> !relay_out[REL_AUX_LO])
    else $error("disallowed aux relay operated");

  c_fault_entry: cover property (st_q == ST_PREFAULT ##1 st_q == ST_FAULT);
  c_post_entry: cover property (st_q == ST_FAULT ##1 st_q == ST_POSTFAULT);
  c_reclose: cover property (st_q == ST_POSTFAULT ##1 st_q == ST_PREFAULT);
  c_forced: cover property (ao_forced && lvl_q[0] == PCT_MAX);

endmodule : test_sim_ctrl
`default_nettype wire

// *** verification/breaker_model.sv ***
`default_nettype none
module breaker_model #(
  parameter int OP_DLY = 3
) (
  input wire logic sys_clk,
  input wire logic trip_coil,
  input wire logic close_coil,
  output logic closed_aux,
  output logic open_aux
);
  timeunit 1ns;
  timeprecision 1ns;
  logic pos_q = 1'b1;
  int cnt_q = 0;
  always_ff @(posedge sys_clk) begin
    if ((trip_coil && pos_q) || (close_coil && !pos_q)) begin
      cnt_q <= cnt_q + 1;
      if (cnt_q == OP_DLY) begin
        pos_q <= !pos_q;
        cnt_q <= 0;
      end
    end else begin
      cnt_q <= 0;
    end
  end
  assign closed_aux = pos_q;
  assign open_aux = !pos_q;
endmodule : breaker_model
`default_nettype wire

// *** verification/test_simulation_controller_bench.sv ***
`default_nettype none
module test_simulation_controller_bench import sim_ctrl_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0;
  logic resetn, ao_en_wr, ao_en_val, ao_lvl_wr, sim_wr, cfg_wr, cfg_cb_sim;
  logic sim_fault_pin, trip_req, close_req, selftest_ok;
  logic [2:0] ao_lvl_idx;
  logic [6:0] ao_lvl_pct;
  logic [1:0] sim_wr_state, sim_state;
  logic [4:0] cfg_allow;
  logic [7:0] relay_req, relay_out;
  logic [N_AO-1:0][14:0] ao_normal_ua, ao_out_ua;
  logic ao_forced, brk_open_ind, brk_closed_ind, sim_active, cb_sim, ac_acq_en;
  logic aux_contacts_ignored, prof_nominal, neutral_zero, neutral_vsum, v0_vsum;
  logic currents_zero, bus_balanced, breaker_closed_aux_contact, breaker_open_aux_contact;
  logic [8:0] bus_ang_a, bus_ang_b, bus_ang_c;
  int error_cnt = 0;
  int compares = 0;

  test_sim_ctrl #(.NUM_AO(N_AO)) u_test_sim_ctrl (.sys_clk(sys_clk), .resetn(resetn),
    .ao_en_wr(ao_en_wr), .ao_en_val(ao_en_val), .ao_lvl_wr(ao_lvl_wr),
    .ao_lvl_idx(ao_lvl_idx), .ao_lvl_pct(ao_lvl_pct), .ao_normal_ua(ao_normal_ua),
    .ao_out_ua(ao_out_ua), .ao_forced(ao_forced), .sim_wr(sim_wr),
    .sim_wr_state(sim_wr_state), .cfg_wr(cfg_wr), .cfg_cb_sim(cfg_cb_sim),
    .cfg_allow(cfg_allow), .sim_fault_pin(sim_fault_pin),
    .breaker_closed_aux_contact(breaker_closed_aux_contact),
    .breaker_open_aux_contact(breaker_open_aux_contact), .trip_req(trip_req),
    .close_req(close_req), .relay_req(relay_req), .selftest_ok(selftest_ok),
    .relay_out(relay_out), .brk_open_ind(brk_open_ind), .brk_closed_ind(brk_closed_ind),
    .sim_active(sim_active), .sim_state(sim_state), .cb_sim(cb_sim), .ac_acq_en(ac_acq_en),
    .aux_contacts_ignored(aux_contacts_ignored), .prof_nominal(prof_nominal),
    .neutral_zero(neutral_zero), .neutral_vsum(neutral_vsum), .v0_vsum(v0_vsum),
    .currents_zero(currents_zero), .bus_balanced(bus_balanced),
    .bus_ang_a(bus_ang_a), .bus_ang_b(bus_ang_b), .bus_ang_c(bus_ang_c));

  breaker_model u_breaker_model (.sys_clk(sys_clk), .trip_coil(relay_out[0]),
    .close_coil(relay_out[1]), .closed_aux(breaker_closed_aux_contact),
    .open_aux(breaker_open_aux_contact));

  initial begin
    forever #50 sys_clk = ~sys_clk;
  end

  task conclude;
    if (error_cnt == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask : chk

  task step(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : step

  task set_st(input logic [1:0] s);
    sim_wr = 1'b1;
    sim_wr_state = s;
    step(1);
    sim_wr = 1'b0;
    step(1);
  endtask : set_st

  task lvl(input logic [2:0] i, input logic [6:0] p);
    ao_lvl_wr = 1'b1;
    ao_lvl_idx = i;
    ao_lvl_pct = p;
    step(1);
    ao_lvl_wr = 1'b0;
    step(1);
  endtask : lvl

  task cfg(input logic cb, input logic [4:0] al);
    cfg_wr = 1'b1;
    cfg_cb_sim = cb;
    cfg_allow = al;
    step(1);
    cfg_wr = 1'b0;
  endtask : cfg

  task aoen(input logic v);
    ao_en_wr = 1'b1;
    ao_en_val = v;
    step(1);
    ao_en_wr = 1'b0;
    step(2);
  endtask : aoen

  task wait_st(input logic [1:0] s);
    for (int i = 0; i < 20 && sim_state !== s; i++) step(1);
    chk("sim_state", s, sim_state);
    if (sim_state !== s) conclude();
  endtask : wait_st

  initial begin
    {resetn, ao_en_wr, ao_en_val, ao_lvl_wr, sim_wr, cfg_wr, cfg_cb_sim} = 7'h00;
    {sim_fault_pin, trip_req, close_req, ao_lvl_idx, ao_lvl_pct} = 13'h0000;
    {sim_wr_state, cfg_allow, relay_req} = 15'h0000;
    selftest_ok = 1'b1;
    for (int k = 0; k < N_AO; k++) ao_normal_ua[k] = 15'(k * 100 + 1000);
    step(2);
    resetn = 1'b1;
    chk("sim_state", 2'h0, sim_state);
    chk("cb_sim", 1'b1, cb_sim);
    chk("ao_forced", 1'b0, ao_forced);
    chk("ac_acq_en", 1'b1, ac_acq_en);
    relay_req = 8'h7c;
    step(3);
    chk("relay_out", 8'hfc, relay_out);
    lvl(0, 7'h32);
    lvl(7, 7'h64);
    lvl(3, 7'h09);
    lvl(3, 7'h00);
    lvl(5, 7'h01);
    lvl(1, 7'h65);
    aoen(1'b1);
    chk("ao_forced", 1'b1, ao_forced);
    chk("ao0", 15'h2ee0, ao_out_ua[0]);
    chk("ao7", UA_HI, ao_out_ua[7]);
    chk("ao3", 15'h0fa0, ao_out_ua[3]);
    chk("ao5", 15'h1040, ao_out_ua[5]);
    chk("ao1", 15'h0fa0, ao_out_ua[1]);
    aoen(1'b0);
    chk("ao2", ao_normal_ua[2], ao_out_ua[2]);
    relay_req = 8'hff;
    cfg(1'b1, 5'h05);
    set_st(ST_PREFAULT);
    step(2);
    chk("sim_active", 1'b1, sim_active);
    chk("ac_acq_en", 1'b0, ac_acq_en);
    chk("prefault", 2'h3, {prof_nominal, neutral_zero});
    chk("relay_out", 8'h14, relay_out);
    chk("aux_ign", 1'b1, aux_contacts_ignored);
    sim_fault_pin = 1'b1;
    wait_st(ST_FAULT);
    sim_fault_pin = 1'b0;
    step(5);
    chk("fault", 4'he, {neutral_vsum, v0_vsum, sim_state});
    trip_req = 1'b1;
    wait_st(ST_POSTFAULT);
    trip_req = 1'b0;
    step(2);
    chk("brk_ind", 2'h2, {brk_open_ind, brk_closed_ind});
    chk("postfault", 2'h3, {currents_zero, bus_balanced});
    chk("bus_ang", {9'h000, 9'h078, 9'h0f0}, {bus_ang_a, bus_ang_b, bus_ang_c});
    close_req = 1'b1;
    wait_st(ST_PREFAULT);
    close_req = 1'b0;
    step(2);
    chk("brk_ind", 2'h1, {brk_open_ind, brk_closed_ind});
    chk("relay_out", 8'h14, relay_out);
    relay_req = 8'h7c;
    set_st(ST_DISABLED);
    step(2);
    chk("disabled", 3'h4, {ac_acq_en, sim_state});
    chk("relay_out", 8'hfc, relay_out);
    cfg(1'b0, 5'h00);
    relay_req = 8'h00;
    set_st(ST_PREFAULT);
    step(3);
    chk("aux_ign", 1'b0, aux_contacts_ignored);
    chk("brk_ind", 2'h1, {brk_open_ind, brk_closed_ind});
    set_st(ST_FAULT);
    relay_req = 8'h01;
    step(2);
    chk("relay_out", 8'h01, relay_out);
    wait_st(ST_POSTFAULT);
    relay_req = 8'h02;
    step(2);
    chk("relay_out", 8'h02, relay_out);
    wait_st(ST_PREFAULT);
    relay_req = 8'h00;
    step(8);
    set_st(ST_FAULT);
    set_st(ST_POSTFAULT);
    set_st(ST_DISABLED);
    step(1);
    chk("sim_state", 2'h0, sim_state);
    conclude();
  end

  initial begin
    repeat (5000) @(posedge sys_clk);
    error_cnt++;
    conclude();
  end
endmodule : test_simulation_controller_bench
`default_nettype wire
